// ---- burst_sram_port.sv ----
`default_nettype none

// Functional notes
// RL1: Array holds 262,144 words of 36 bits, four byte lanes.
// RL2: Write data is taken from the bus two cycles after its command.
// RL3: Read data drives the bus two cycles after the read command.
// RL4: Reads and writes mix back to back without idle cycles.
// RL5: Controller drives read select low for write, high for read.
// RL6: Each byte strobe gates its own lane; all active writes whole word.
// RL7: Write controls and address register on the command's rising edge.
// RL8: Writes complete regardless of the output drive enable.
// RL9: Any chip select inactive floats the data outputs.
// RL10: Deselect reaches the bus two cycles later; in-flight work completes.
// RL11: On advance, address, chip selects and read select are ignored.
// RL12: Each advance steps the burst counter in the selected order.
// RL13: Advance continues reads, writes and deselects from the last load.
// RL14: Clock hold high freezes every operation and all internal state; the write staging FIFO still drains to the array.
// RL15: Output drive enable acts combinationally on the data pins.
// RL16: Data pins form one shared bus, split into in, out, enable.
// RL17: Load cycle takes a fresh address and samples chip selects.
// RL18: Interleaved steps start XOR count; linear increments modulo four.
// RL19: Clock hold high keeps current address and operation.
// RL20: Snooze ignores all inputs except its request and floats outputs.
// RL21: Byte strobes ride the two-cycle pipeline with their write.
// RL22: Controller tracks the two-stage pipeline for data timing.

package burst_sram_pkg;

   // Array shape: 262,144 words of four byte lanes, 9 bits each (36-bit variant)
   localparam int unsigned WORD_COUNT = 262144;
   localparam int unsigned ADDR_W     = 18;
   localparam int unsigned LANES      = 4;
   localparam int unsigned LANE_W     = 9;
   localparam int unsigned DATA_W     = LANES * LANE_W;

   // Pipeline depth for both read data and write data
   localparam int unsigned LATENCY    = 2;

   // Burst counter field
   localparam int unsigned BURST_W    = 2;
   localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;

   // Depth of the write data staging FIFO
   localparam int unsigned FIFO_DEPTH = 32;

   // Operation held by the burst engine
   typedef enum logic [1:0] {
      OP_IDLE,
      OP_READ,
      OP_WRITE
   } op_t;

endpackage

// Circular buffer with an occupancy count; one push and one pop per cycle
module word_fifo #(
   parameter int unsigned WIDTH = 36,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int unsigned PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [PTR_W:0]   count_q;
   logic             push;
   logic             pop;

   // Full and empty come straight from the occupancy count
   // The count is one bit wider than the pointers, so full and empty differ
   assign in_ready  = (count_q != (PTR_W+1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data  = mem[rd_ptr_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage write
   always_ff @(posedge ref_clk)
   begin
      if (push)
      begin
         mem[wr_ptr_q] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= PTR_W'(wr_ptr_q + 1'b1);
         end
         if (pop)
         begin
            rd_ptr_q <= PTR_W'(rd_ptr_q + 1'b1);
         end
         if (push && !pop)
         begin
            count_q <= (PTR_W+1)'(count_q + 1'b1);
         end
         else if (pop && !push)
         begin
            count_q <= (PTR_W+1)'(count_q - 1'b1);
         end
      end
   end

endmodule

module burst_sram_port (
   input  wire logic                                  ref_clk,
   input  wire logic                                  rst_b,
   input  wire logic                                  clock_hold_n,
   input  wire logic                                  advance_or_load_select,
   input  wire logic                                  read_not_write,
   input  wire logic [burst_sram_pkg::LANES-1:0]      byte_lane_write_strobes_n,
   input  wire logic                                  chip_select_first_n,
   input  wire logic                                  chip_select_second,
   input  wire logic                                  chip_select_third_n,
   input  wire logic [burst_sram_pkg::ADDR_W-1:0]     address,
   input  wire logic                                  burst_order_select,
   input  wire logic                                  output_enable_n,
   input  wire logic                                  snooze_request,
   input  wire logic [burst_sram_pkg::DATA_W-1:0]     data_in,
   output logic      [burst_sram_pkg::DATA_W-1:0]     data_out,
   output logic                                       data_oe,
   output logic                                       write_stage_ready
);

   // Short local names for the package constants
   localparam int unsigned LAT    = burst_sram_pkg::LATENCY;
   localparam int unsigned AW     = burst_sram_pkg::ADDR_W;
   localparam int unsigned DW     = burst_sram_pkg::DATA_W;
   localparam int unsigned NL     = burst_sram_pkg::LANES;
   localparam int unsigned LW     = burst_sram_pkg::LANE_W;
   localparam int unsigned BW     = burst_sram_pkg::BURST_W;
   localparam int unsigned WR_W   = AW + NL;

   // RL1 storage array
   logic [DW-1:0] mem [burst_sram_pkg::WORD_COUNT];

   // Burst engine state
   burst_sram_pkg::op_t op_q;
   logic [AW-1:0]       base_addr_q;
   logic [BW-1:0]       burst_cnt_q;
   logic                interleave_q;

   // Two-stage pipeline, index 0 is one cycle after the command
   logic [LAT-1:0]      rd_pipe_q;
   logic [LAT-1:0]      wr_pipe_q;
   logic [AW-1:0]       addr_pipe_q [LAT];
   logic [NL-1:0]       strobe_pipe_q [LAT];

   logic [DW-1:0]       rd_data_q;
   logic                rd_valid_q;

   logic                run;
   logic                load;
   logic                selected;
   burst_sram_pkg::op_t cur_op;
   logic [AW-1:0]       cur_addr;
   logic [NL-1:0]       cur_strobe_n;
   logic [BW-1:0]       next_cnt;
   logic [BW-1:0]       step_bits;

   // FIFO staging of captured write data
   logic                fifo_in_valid;
   logic                fifo_out_valid;
   logic [WR_W+DW-1:0]  fifo_in_data;
   logic [WR_W+DW-1:0]  fifo_out_data;

   // RL14 RL19 RL20 clock hold and snooze freeze the burst engine and pipelines, not the write staging FIFO
   assign run  = clock_hold_n == 1'b0 && !snooze_request;

   // RL17 load cycle decode
   assign load     = !advance_or_load_select;
   assign selected = !chip_select_first_n && chip_select_second && !chip_select_third_n;

   // RL18 burst order: interleaved XORs the count, linear adds it
   assign next_cnt  = BW'(burst_cnt_q + burst_sram_pkg::BURST_ONE);
   assign step_bits = interleave_q ? (base_addr_q[BW-1:0] ^ next_cnt)
                                   : BW'(base_addr_q[BW-1:0] + next_cnt);

   // RL11 RL13 operation and address of this cycle
   always_comb
   begin
      cur_strobe_n = byte_lane_write_strobes_n;
      if (load)
      begin
         cur_addr = address;
         if (!selected)
         begin
            cur_op = burst_sram_pkg::OP_IDLE;
         end
         else if (read_not_write)
         begin
            cur_op = burst_sram_pkg::OP_READ;
         end
         else
         begin
            cur_op = burst_sram_pkg::OP_WRITE;
         end
      end
      else
      begin
         cur_op   = op_q;
         cur_addr = {base_addr_q[AW-1:BW], step_bits};
      end
   end

   // RL12 burst engine: load or step, held when frozen
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         op_q         <= burst_sram_pkg::OP_IDLE;
         base_addr_q  <= '0;
         burst_cnt_q  <= '0;
         interleave_q <= 1'b1;
      end
      else if (run)
      begin
         op_q <= cur_op;
         if (load)
         begin
            base_addr_q  <= address;
            burst_cnt_q  <= '0;
            interleave_q <= burst_order_select;
         end
         else
         begin
            burst_cnt_q <= next_cnt;
         end
      end
   end

   // RL7 RL21 RL10 command, address and strobes enter the pipeline
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         rd_pipe_q <= '0;
         wr_pipe_q <= '0;
         for (int i = 0; i < LAT; i++)
         begin
            addr_pipe_q[i]   <= '0;
            strobe_pipe_q[i] <= '1;
         end
      end
      else if (run)
      begin
         rd_pipe_q        <= {rd_pipe_q[LAT-2:0], cur_op == burst_sram_pkg::OP_READ};
         wr_pipe_q        <= {wr_pipe_q[LAT-2:0], cur_op == burst_sram_pkg::OP_WRITE};
         addr_pipe_q[0]   <= cur_addr;
         strobe_pipe_q[0] <= cur_strobe_n;
         for (int i = 1; i < LAT; i++)
         begin
            addr_pipe_q[i]   <= addr_pipe_q[i-1];
            strobe_pipe_q[i] <= strobe_pipe_q[i-1];
         end
      end
   end

   // Staging keeps the commit off the read path; a read one or two cycles after
   // a write to the same word still returns the older contents
   // RL2 capture write data at the second stage into the staging FIFO
   assign fifo_in_valid = run && wr_pipe_q[LAT-1];
   assign fifo_in_data  = {addr_pipe_q[LAT-1], strobe_pipe_q[LAT-1], data_in};

   word_fifo #(
      .WIDTH (WR_W + DW),
      .DEPTH (burst_sram_pkg::FIFO_DEPTH)
   ) u_write_stage (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .in_valid  (fifo_in_valid),
      .in_ready  (write_stage_ready),
      .in_data   (fifo_in_data),
      .out_valid (fifo_out_valid),
      .out_ready (1'b1),
      .out_data  (fifo_out_data)
   );

   // RL6 RL8 per-lane commit, independent of output enable
   always_ff @(posedge ref_clk)
   begin
      if (fifo_out_valid)
      begin
         for (int l = 0; l < NL; l++)
         begin
            if (!fifo_out_data[DW + l])
            begin
               mem[fifo_out_data[DW+NL +: AW]][l*LW +: LW] <= fifo_out_data[l*LW +: LW];
            end
         end
      end
   end

   // RL3 RL4 read data fetched to land two cycles after the command
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         rd_data_q  <= '0;
         rd_valid_q <= 1'b0;
      end
      else if (run)
      begin
         rd_valid_q <= rd_pipe_q[LAT-2];
         if (rd_pipe_q[LAT-2])
         begin
            rd_data_q <= mem[addr_pipe_q[LAT-2]];
         end
      end
   end

   // Output enable bypasses the clock so the pins release at once
   // RL15 RL16 RL9 RL20 drive only for a read slot with output enable low
   assign data_out = rd_data_q;
   assign data_oe  = rd_valid_q && !output_enable_n && !snooze_request;

endmodule

`default_nettype wire

// ---- burst_sram_pkg.sv ----
`default_nettype none


`default_nettype wire

// ---- word_fifo.sv ----
`default_nettype none


`default_nettype wire

// ---- burst_sram_port_properties.sv ----
`default_nettype none
module sram_port_checker (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clock_hold_n,
   input wire logic advance_or_load_select,
   input wire logic read_not_write,
   input wire logic chip_select_first_n,
   input wire logic chip_select_second,
   input wire logic chip_select_third_n,
   input wire logic output_enable_n,
   input wire logic snooze_request,
   input wire logic data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // Edges move the pipeline only without hold or snooze
   logic go, sel, rd, wr, ds, burst_advance_input, vis;
   assign go = !clock_hold_n && !snooze_request;
   assign sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
   assign rd = go && !advance_or_load_select && sel && read_not_write;
   assign wr = go && !advance_or_load_select && sel && !read_not_write;
   assign ds = go && !advance_or_load_select && !sel;
   assign burst_advance_input = go && advance_or_load_select;
   assign vis = !output_enable_n && !snooze_request;
   oe_release_a: assert property (output_enable_n |-> !data_oe)
      else $error("driven while disabled");
   snooze_float_a: assert property (snooze_request |-> !data_oe)
      else $error("driven in snooze");
   read_latency_a: assert property (rd ##1 go ##1 vis |-> data_oe)
      else $error("read beat missing");
   write_slot_a: assert property (wr ##1 go |=> !data_oe)
      else $error("write slot driven");
   desel_float_a: assert property (ds ##1 go |=> !data_oe)
      else $error("deselect driven");
   burst_read_a: assert property (rd ##1 burst_advance_input ##1 go ##1 vis |-> data_oe)
      else $error("burst beat missing");
   desel_cont_a: assert property (ds ##1 burst_advance_input ##1 go |=> !data_oe)
      else $error("continued deselect driven");
   hold_stand_a: assert property (clock_hold_n |=> $stable(data_oe)
      || $changed(output_enable_n) || $changed(snooze_request)) else $error("moved in hold");
   cover property (rd ##1 burst_advance_input);
   cover property (wr ##1 burst_advance_input);
   cover property (clock_hold_n ##1 go);
endmodule
bind burst_sram_port sram_port_checker chk (
   .ref_clk                (ref_clk),
   .rst_b                  (rst_b),
   .clock_hold_n           (clock_hold_n),
   .advance_or_load_select (advance_or_load_select),
   .read_not_write         (read_not_write),
   .chip_select_first_n    (chip_select_first_n),
   .chip_select_second     (chip_select_second),
   .chip_select_third_n    (chip_select_third_n),
   .output_enable_n        (output_enable_n),
   .snooze_request         (snooze_request),
   .data_oe                (data_oe)
);
`default_nettype wire

// ---- bus_ctrl_model.sv ----
`default_nettype none
module bus_ctrl_model (
   input  wire logic        ref_clk,
   input  wire logic        stall,
   input  wire logic        wr_beat,
   input  wire logic [35:0] wr_word,
   input  wire logic        data_oe,
   input  wire logic [35:0] data_out,
   output logic      [35:0] bus
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0]  slot_q = 2'h0;
   logic [35:0] w1_q, w2_q, last_q = 36'h0;
   // write word rides two unstalled edges
   always @(posedge ref_clk)
   begin
      last_q <= bus;
      if (!stall)
      begin
         slot_q <= {slot_q[0], wr_beat};
         w1_q <= wr_word;
         w2_q <= w1_q;
      end
   end
   // shared bus; an undriven bus flips so stale data never matches
   assign bus = data_oe ? data_out : (slot_q[1] ? w2_q : ~last_q);
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'h0, rst_b = 1'h0, clock_hold_n = 1'h0, read_not_write = 1'h0;
   logic advance_or_load_select = 1'h0, chip_select_first_n = 1'h1, wr_beat = 1'h0;
   logic chip_select_second = 1'h1, chip_select_third_n = 1'h0, ord = 1'h1;
   logic burst_order_select = 1'h1, output_enable_n = 1'h0, snooze_request = 1'h0;
   logic data_oe, write_stage_ready;
   logic [1:0] cnt = 2'h0, kind = 2'h0, dsel = 2'h0;
   logic [3:0] byte_lane_write_strobes_n = 4'hF;
   logic [17:0] address = 18'h0, base = 18'h0;
   logic [35:0] data_in, data_out, wr_word = 36'h0, pat = 36'h0;
   logic [35:0] mdl [logic [17:0]];
   logic [36:0] expq [$] = '{37'h0, 37'h0};
   int failures = 0, checked = 0, cycles = 0;
   burst_sram_port dut (
      .ref_clk                   (ref_clk),
      .rst_b                     (rst_b),
      .clock_hold_n              (clock_hold_n),
      .advance_or_load_select    (advance_or_load_select),
      .read_not_write            (read_not_write),
      .byte_lane_write_strobes_n (byte_lane_write_strobes_n),
      .chip_select_first_n       (chip_select_first_n),
      .chip_select_second        (chip_select_second),
      .chip_select_third_n       (chip_select_third_n),
      .address                   (address),
      .burst_order_select        (burst_order_select),
      .output_enable_n           (output_enable_n),
      .snooze_request            (snooze_request),
      .data_in                   (data_in),
      .data_out                  (data_out),
      .data_oe                   (data_oe),
      .write_stage_ready         (write_stage_ready)
   );
   bus_ctrl_model ctrl (.ref_clk(ref_clk), .stall(clock_hold_n || snooze_request),
      .wr_beat(wr_beat), .wr_word(wr_word), .data_oe(data_oe), .data_out(data_out),
      .bus(data_in));
   // Clock, 5 ns period
   initial
   begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   // Hang guard, well above the hundred or so cycles used
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         failures++;
         final_report();
      end
   end
   task automatic check(input logic [36:0] seen, input logic [36:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // One bus cycle; op 0 deselect, 1 read, 2 write, 3 advance with junk on ignored pins
   task automatic step(input logic [1:0] op, input logic [17:0] a, input logic [3:0] s);
      logic [17:0] ea;
      logic [35:0] wd;
      logic [36:0] ex;
      advance_or_load_select <= (op == 2'h3);
      read_not_write <= (op == 2'h1);
      // each deselect lifts a different one of the three selects
      chip_select_first_n <= (op == 2'h3) || (op == 2'h0 && dsel == 2'h0);
      chip_select_second <= !(op == 2'h0 && dsel == 2'h1);
      chip_select_third_n <= (op == 2'h0 && dsel == 2'h2);
      if (op == 2'h0)
         dsel = (dsel == 2'h2) ? 2'h0 : dsel + 2'h1;
      address <= (op == 2'h3) ? ~a : a;
      byte_lane_write_strobes_n <= s;
      burst_order_select <= ord;
      if (op == 2'h3)
         cnt = cnt + 2'h1;
      else
      begin
         base = a;
         cnt = 2'h0;
         kind = op;
      end
      ea = {base[17:2], ord ? base[1:0] ^ cnt : base[1:0] + cnt};
      wd = {ea, ~ea} ^ pat;
      wr_beat <= (kind == 2'h2);
      wr_word <= wd;
      ex = 37'h0;
      for (int l = 0; l < 4; l++)
         if (kind == 2'h2 && !s[l])
            mdl[ea][l*9 +: 9] = wd[l*9 +: 9];
      if (kind == 2'h1)
         ex = {1'h1, mdl[ea]};
      expq.push_back(ex);
      @(posedge ref_clk);
      ex = expq.pop_front();
      if (ex[36] && !output_enable_n)
         check({data_oe, data_in}, ex);
      else
         check({36'h0, data_oe}, 37'h0);
   endtask
   task automatic idle(input int n);
      repeat (n) step(2'h0, 18'h0, 4'hF);
   endtask
   task automatic hold(input int n);
      clock_hold_n <= 1'h1;
      repeat (n) @(posedge ref_clk);
      clock_hold_n <= 1'h0;
   endtask
   task automatic fin(input string n);
      idle(3);
      check({36'h0, write_stage_ready}, 37'h1);
      $display("%s done", n);
   endtask
   // reads and writes alternate with no gap
   task automatic t_mix();
      pat = 36'h5A5A5A5A5;
      for (int i = 0; i < 4; i++)
         step(2'h2, 18'h100 + 18'(i), 4'h0);
      idle(1);
      for (int i = 0; i < 4; i++)
      begin
         step(2'h1, 18'h100 + 18'(i), 4'hF);
         step(2'h2, 18'h200 + 18'(i), 4'h0);
      end
      fin("mix");
   endtask
   // burst write, single reads, burst read, both orders
   task automatic t_burst();
      for (int o = 0; o < 2; o++)
      begin
         ord = o[0];
         pat = o[0] ? 36'hF0F0F0F0F : 36'h0A0A0A0A0;
         step(2'h2, 18'h301, 4'h0);
         repeat (3) step(2'h3, 18'h301, 4'h0);
         idle(3);
         for (int i = 0; i < 4; i++)
            step(2'h1, 18'h300 + 18'(i), 4'hF);
         step(2'h1, 18'h301, 4'hF);
         repeat (3) step(2'h3, 18'h301, 4'hF);
         fin("burst");
      end
   endtask
   task automatic t_lanes();
      pat = 36'h123456789;
      step(2'h2, 18'h40, 4'h0);
      pat = 36'hFEDCBA987;
      step(2'h2, 18'h40, 4'hA);
      idle(5);
      step(2'h1, 18'h40, 4'hF);
      fin("lanes");
   endtask
   task automatic t_hold();
      step(2'h1, 18'h40, 4'hF);
      hold(3);
      step(2'h2, 18'h41, 4'h0);
      hold(2);
      idle(5);
      step(2'h1, 18'h41, 4'hF);
      fin("hold");
   endtask
   task automatic t_desel();
      step(2'h1, 18'h101, 4'hF);
      step(2'h0, 18'h0, 4'hF);
      step(2'h3, 18'h0, 4'hF);
      step(2'h1, 18'h102, 4'hF);
      output_enable_n <= 1'h1;
      step(2'h1, 18'h103, 4'hF);
      idle(3);
      output_enable_n <= 1'h0;
      snooze_request <= 1'h1;
      // a read offered in snooze is ignored; the closing idles see no beat
      advance_or_load_select <= 1'h0;
      read_not_write <= 1'h1;
      chip_select_first_n <= 1'h0;
      chip_select_second <= 1'h1;
      chip_select_third_n <= 1'h0;
      repeat (2)
      begin
         @(posedge ref_clk);
         check({36'h0, data_oe}, 37'h0);
      end
      snooze_request <= 1'h0;
      fin("desel");
   endtask
   initial
   begin
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'h1;
      t_mix();
      t_burst();
      t_lanes();
      t_hold();
      t_desel();
      final_report();
   end
endmodule
`default_nettype wire
